// ==== epwm_deadband.sv ====
// Rising-edge delay for one half-bridge output.
module epwm_deadband
  import epwm_pkg::*;
#(
  parameter int UW = DB_W,
  parameter int CW = DB_CNT_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic bypass,
  input wire logic level,
  input wire logic [UW-1:0] delayUnits,
  output logic delayed
);

  logic levelQ;
  logic [CW-1:0] remain;

  wire rise = level && !levelQ;
  wire [CW-1:0] loadValue = CW'(delayUnits) * CW'(DB_UNIT_CYCLES);
  wire loadZero = loadValue == '0;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      levelQ <= 1'b0;
      remain <= '0;
    end else begin
      levelQ <= level;
      if (rise && !loadZero) begin
        remain <= loadValue - 1'b1;
      end else if (!level) begin
        remain <= '0;
      end else if (remain != '0) begin
        remain <= remain - 1'b1;
      end
    end
  end

  // A level that falls before the count ends never becomes active.
  assign delayed = level && (bypass || (rise ? loadZero : remain == '0));

endmodule

// ==== epwm_pkg.sv ====
// Shared constants for the enhanced PWM output steering block.
package epwm_pkg;

  // Register port geometry.
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // Register offsets.
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_PERIOD = 8'h04;
  localparam logic [7:0] REG_DUTY = 8'h08;
  localparam logic [7:0] REG_DEADBAND = 8'h0c;
  localparam logic [7:0] REG_STATUS = 8'h10;
  localparam logic [7:0] REG_LATCH = 8'h14;

  // Field positions in the control register.
  localparam int CTRL_EN = 0;
  localparam int CTRL_MODE_LO = 1;
  localparam int CTRL_POL_LO = 3;
  localparam int CTRL_PRE_LO = 5;
  localparam int CTRL_STEER_LO = 8;
  localparam int CTRL_DIRL_LO = 12;

  // Field positions in the status register.
  localparam int STAT_SUB_LO = 8;
  localparam int STAT_RUN = 10;
  localparam int STAT_MODE_LO = 11;
  localparam int STAT_PEND = 13;
  localparam int STAT_PIN_LO = 16;

  // Field widths.
  localparam int TMR_W = 8;
  localparam int DUTY_W = 10;
  localparam int DB_W = 7;
  localparam int DB_CNT_W = 9;

  // Reset values.
  localparam logic [3:0] DIR_LATCH_RESET = 4'hf;
  localparam logic [7:0] PERIOD_RESET = 8'hff;

  // Output mode field encodings.
  localparam logic [1:0] MODE_SINGLE = 2'h0;
  localparam logic [1:0] MODE_FWD = 2'h1;
  localparam logic [1:0] MODE_HALF = 2'h2;
  localparam logic [1:0] MODE_REV = 2'h3;
  localparam int MODE_DIR_BIT = 1;

  // Prescaler selections and the last oscillator count of one timer tick.
  localparam logic [1:0] PRE_SEL_1 = 2'h0;
  localparam logic [1:0] PRE_SEL_4 = 2'h1;
  localparam logic [5:0] PRE_LIMIT_1 = 6'h03;
  localparam logic [5:0] PRE_LIMIT_4 = 6'h0f;
  localparam logic [5:0] PRE_LIMIT_16 = 6'h3f;
  localparam logic [1:0] SUB_LAST = 2'h3;

  // Timing: one dead-band unit is one instruction cycle of four oscillator periods.
  localparam int CLK_PERIOD_NS = 10;
  localparam int OSC_PER_INSTR = 4;
  localparam int DB_UNIT_NS = OSC_PER_INSTR * CLK_PERIOD_NS;
  localparam int DB_UNIT_CYCLES = (DB_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

// ==== epwm_steering.sv ====
// Enhanced PWM output stage: register port, duty compare and four-pin steering.

// Overview of operation
// - Ten-bit base: period timer plus sub-count.
// - Mode field selects single, half, forward, reverse.
// - Single mode drives only steering-selected outputs.
// - Dead band is four oscillator periods per unit.
// - Half-bridge: PWM on A, complement on B.
// - Half-bridge delays each inactive-to-active edge.
// - Delay beyond duty keeps output inactive.
// - Forward: A active, D modulated, B C inactive.
// - Reverse: C active, B modulated, A D inactive.
// - New direction applies at next PWM cycle.
// - Direction change idles B D, swaps A C.
// - A and C switch one sub-count slice early.
// - No dead band in full-bridge modes.
// - Unused pins are left undriven.
// - Polarity chosen per pair A/C and B/D.
// - Output waits for first new period after enable.
// - Duty latch loads only at period match.
module epwm_steering
  import epwm_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [DATA_W-1:0] regRdData,
  output logic outA,
  output logic outAEn,
  output logic outB,
  output logic outBEn,
  output logic outC,
  output logic outCEn,
  output logic outD,
  output logic outDEn
);

  // Software-visible settings.
  logic enable;
  logic [1:0] outputModeField;
  logic [1:0] outputPolarityField;
  logic [1:0] prescaleSel;
  logic [3:0] steer;
  logic [3:0] pinDirectionLatch;
  logic [TMR_W-1:0] periodMatchValue;
  logic [DUTY_W-1:0] duty;
  logic [DB_W-1:0] deadbandCount;

  // Block state.
  logic running;
  logic [1:0] appliedMode;
  logic [DUTY_W-1:0] dutyCompareLatch;
  logic pwmRaw;
  logic [3:0] pinLevel;
  logic [3:0] pinEnable;

  logic [TMR_W-1:0] periodTimer;
  logic [1:0] subCount;
  logic periodStart;
  logic lastSlice;
  logic halfA;
  logic halfB;
  logic [3:0] active;
  logic [3:0] used;

  // Address decode.
  wire hitCtrl = regAddr == REG_CTRL;
  wire hitPeriod = regAddr == REG_PERIOD;
  wire hitDuty = regAddr == REG_DUTY;
  wire hitDeadband = regAddr == REG_DEADBAND;
  wire hitStatus = regAddr == REG_STATUS;
  wire hitLatch = regAddr == REG_LATCH;

  wire [DUTY_W-1:0] timeBase = {periodTimer, subCount};
  wire modeIsFull = outputModeField[0];
  wire appliedIsFull = appliedMode[0];
  wire appliedIsHalf = appliedMode == MODE_HALF;
  // The compare drops the waveform in the very cycle the time base reaches the duty value.
  wire pwmLive = pwmRaw && (timeBase != dutyCompareLatch);
  wire newDir = outputModeField[MODE_DIR_BIT];

  // A direction write may land anywhere in the cycle; it only arms a pending change.
  wire dirPending = running && appliedIsFull && modeIsFull
    && (newDir != appliedMode[MODE_DIR_BIT]);

  wire [3:0] polarityInvert = {outputPolarityField[0], outputPolarityField[1],
    outputPolarityField[0], outputPolarityField[1]};

  wire [DATA_W-1:0] ctrlView = DATA_W'({pinDirectionLatch, steer, 1'b0,
    prescaleSel, outputPolarityField, outputModeField, enable});
  wire [DATA_W-1:0] statusView = DATA_W'({pinLevel, 2'b00, dirPending, appliedMode,
    running, subCount, periodTimer});
  wire [DATA_W-1:0] readMux =
    hitCtrl ? ctrlView :
    hitPeriod ? DATA_W'(periodMatchValue) :
    hitDuty ? DATA_W'(duty) :
    hitDeadband ? DATA_W'(deadbandCount) :
    hitStatus ? statusView :
    hitLatch ? DATA_W'(dutyCompareLatch) : 32'h0000_0000;

  epwm_timebase #(
    .TW(TMR_W)
  ) u_timebase (
    .mclk(mclk),
    .resetn(resetn),
    .run(enable),
    .prescaleSel(prescaleSel),
    .periodValue(periodMatchValue),
    .timer(periodTimer),
    .subCount(subCount),
    .periodStart(periodStart),
    .lastSlice(lastSlice)
  );

  // Each half-bridge leg gets its own delay on its rising edge.
  epwm_deadband #(
    .UW(DB_W),
    .CW(DB_CNT_W)
  ) u_deadband_a (
    .mclk(mclk),
    .resetn(resetn),
    .bypass(!appliedIsHalf),
    .level(running && pwmLive),
    .delayUnits(deadbandCount),
    .delayed(halfA)
  );

  epwm_deadband #(
    .UW(DB_W),
    .CW(DB_CNT_W)
  ) u_deadband_b (
    .mclk(mclk),
    .resetn(resetn),
    .bypass(!appliedIsHalf),
    .level(running && !pwmLive),
    .delayUnits(deadbandCount),
    .delayed(halfB)
  );

  // Register writes.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      enable <= 1'b0;
      outputModeField <= MODE_SINGLE;
      outputPolarityField <= 2'b00;
      prescaleSel <= PRE_SEL_1;
      steer <= 4'h0;
      pinDirectionLatch <= DIR_LATCH_RESET;
      periodMatchValue <= PERIOD_RESET;
      duty <= '0;
      deadbandCount <= '0;
    end else if (regWrite) begin
      if (hitCtrl) begin
        enable <= regWrData[CTRL_EN];
        outputModeField <= regWrData[CTRL_MODE_LO +: 2];
        outputPolarityField <= regWrData[CTRL_POL_LO +: 2];
        prescaleSel <= regWrData[CTRL_PRE_LO +: 2];
        steer <= regWrData[CTRL_STEER_LO +: 4];
        pinDirectionLatch <= regWrData[CTRL_DIRL_LO +: 4];
      end
      if (hitPeriod) begin
        periodMatchValue <= regWrData[TMR_W-1:0];
      end
      if (hitDuty) begin
        duty <= regWrData[DUTY_W-1:0];
      end
      if (hitDeadband) begin
        deadbandCount <= regWrData[DB_W-1:0];
      end
    end
  end

  // Read data stands only in the cycle after the read strobe.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      regRdData <= '0;
    end else begin
      regRdData <= regRead ? readMux : '0;
    end
  end

  // Period bookkeeping and the raw compare waveform.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      running <= 1'b0;
      appliedMode <= MODE_SINGLE;
      dutyCompareLatch <= '0;
      pwmRaw <= 1'b0;
    end else if (!enable) begin
      running <= 1'b0;
      appliedMode <= outputModeField;
      pwmRaw <= 1'b0;
    end else if (periodStart) begin
      running <= 1'b1;
      appliedMode <= outputModeField;
      dutyCompareLatch <= duty;
      pwmRaw <= duty != '0;
    end else begin
      if (!running) begin
        appliedMode <= outputModeField;
      end
      if (timeBase == dutyCompareLatch) begin
        pwmRaw <= 1'b0;
      end
    end
  end

  // Active levels per pin, index 0 is A through 3 is D.
  always_comb begin
    active = 4'h0;
    used = 4'h0;
    case (appliedMode)
      MODE_SINGLE: begin
        active = steer & {4{pwmLive}};
        used = steer;
      end
      MODE_HALF: begin
        active = {1'b0, 1'b0, halfB, halfA};
        used = 4'h3;
      end
      MODE_FWD: begin
        active = {pwmLive, 1'b0, 1'b0, 1'b1};
        used = 4'hf;
      end
      MODE_REV: begin
        active = {1'b0, 1'b1, pwmLive, 1'b0};
        used = 4'hf;
      end
      default: begin
        active = 4'h0;
        used = 4'h0;
      end
    endcase
    if (dirPending) begin
      active[1] = 1'b0;
      active[3] = 1'b0;
      if (lastSlice) begin
        active[0] = !newDir;
        active[2] = newDir;
      end
    end
    if (!running) begin
      active = 4'h0;
    end
  end

  // Pins are registered; a pin is driven only when used and its latch is cleared.
  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pinLevel <= 4'h0;
      pinEnable <= 4'h0;
    end else begin
      pinLevel <= active ^ polarityInvert;
      pinEnable <= {4{enable}} & used & ~pinDirectionLatch;
    end
  end

  assign outA = pinLevel[0];
  assign outB = pinLevel[1];
  assign outC = pinLevel[2];
  assign outD = pinLevel[3];
  assign outAEn = pinEnable[0];
  assign outBEn = pinEnable[1];
  assign outCEn = pinEnable[2];
  assign outDEn = pinEnable[3];

endmodule

// ==== epwm_steering_properties.sv ====
// Port-level concurrent checks for the PWM output steering block.
module epwm_steering_properties
  import epwm_pkg::*;
(
  input wire logic mclk,
  input wire logic resetn,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic [DATA_W-1:0] regWrData,
  input wire logic regWrite,
  input wire logic regRead,
  input wire logic [DATA_W-1:0] regRdData,
  input wire logic outA,
  input wire logic outAEn,
  input wire logic outB,
  input wire logic outBEn,
  input wire logic outC,
  input wire logic outCEn,
  input wire logic outD,
  input wire logic outDEn
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [15:0] ctrlSh;
  logic [7:0] perSh;
  logic [9:0] dutySh;
  logic [6:0] dbSh;
  wire logic [3:0] en = {outDEn, outCEn, outBEn, outAEn};
  wire logic ctrlWr = regWrite && regAddr == REG_CTRL;

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      ctrlSh <= 16'hf000;
      perSh <= PERIOD_RESET;
      dutySh <= '0;
      dbSh <= '0;
    end else if (regWrite) begin
      if (regAddr == REG_CTRL) ctrlSh <= regWrData[15:0] & 16'hff7f;
      if (regAddr == REG_PERIOD) perSh <= regWrData[7:0];
      if (regAddr == REG_DUTY) dutySh <= regWrData[9:0];
      if (regAddr == REG_DEADBAND) dbSh <= regWrData[6:0];
    end
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);

  sequence rd_s(logic [7:0] a);
    regRead && regAddr == a;
  endsequence

  rd_idle_zero_a:
    assert property (!$past(regRead) |-> regRdData == '0) else $error("read data outside slot");
  ctrl_readback_a:
    assert property (rd_s(REG_CTRL) |=> (regRdData[15:0] & 16'hff7f) == $past(ctrlSh))
      else $error("control read mismatch");
  period_readback_a:
    assert property (rd_s(REG_PERIOD) |=> regRdData[7:0] == $past(perSh))
      else $error("period read mismatch");
  duty_readback_a:
    assert property (rd_s(REG_DUTY) |=> regRdData[9:0] == $past(dutySh))
      else $error("duty read mismatch");
  delay_readback_a:
    assert property (rd_s(REG_DEADBAND) |=> regRdData[6:0] == $past(dbSh))
      else $error("dead band read mismatch");
  unmapped_zero_a:
    assert property (regRead && regAddr > REG_LATCH |=> regRdData == '0)
      else $error("unmapped read not zero");
  pin_a_gate_a:
    assert property (outAEn |-> $past(ctrlSh[CTRL_EN]) && !$past(ctrlSh[CTRL_DIRL_LO]))
      else $error("pin A driven while not allowed");
  pin_d_gate_a:
    assert property (outDEn |-> $past(ctrlSh[CTRL_EN]) && !$past(ctrlSh[CTRL_DIRL_LO+3]))
      else $error("pin D driven while not allowed");
  off_drops_en_a:
    assert property (ctrlWr && !regWrData[CTRL_EN] |=> ##1 en == 4'h0)
      else $error("enables stay after disable");
  full_no_shoot_a:
    assert property (&en && ctrlSh[4:3] == 2'b00 |-> !(outA && outC) && !(outB && outD)
      && !(outA && outB) && !(outC && outD)) else $error("bridge leg shoot-through");
endmodule

bind epwm_steering epwm_steering_properties u_epwm_steering_properties (
  .mclk(mclk), .resetn(resetn), .regAddr(regAddr), .regWrData(regWrData),
  .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
  .outA(outA), .outAEn(outAEn), .outB(outB), .outBEn(outBEn),
  .outC(outC), .outCEn(outCEn), .outD(outD), .outDEn(outDEn)
);

// ==== epwm_steering_unused_guard.sv ====
// Intentionally empty: no logic of the steering block lives in this file.

// ==== epwm_switch_model.sv ====
// Power switch side model: gate lines with pull-downs.
module epwm_switch_model
(
  input wire logic [3:0] drive,
  input wire logic [3:0] driveEn,
  output logic [3:0] gate
);
  timeunit 1ns;
  timeprecision 1ps;
  // A pin that the block does not drive falls to its pull-down, so the switch stays off.
  assign gate = drive & driveEn;
endmodule

// ==== epwm_timebase.sv ====
// Period timer with prescaler forming the 10-bit PWM time base.
module epwm_timebase
  import epwm_pkg::*;
#(
  parameter int TW = TMR_W
) (
  input wire logic mclk,
  input wire logic resetn,
  input wire logic run,
  input wire logic [1:0] prescaleSel,
  input wire logic [TW-1:0] periodValue,
  output logic [TW-1:0] timer,
  output logic [1:0] subCount,
  output logic periodStart,
  output logic lastSlice
);

  logic [5:0] pre;

  wire sel1 = prescaleSel == PRE_SEL_1;
  wire sel4 = prescaleSel == PRE_SEL_4;
  wire [5:0] preLimit = sel1 ? PRE_LIMIT_1 : (sel4 ? PRE_LIMIT_4 : PRE_LIMIT_16);
  wire tick = run && (pre >= preLimit);
  wire periodMatch = timer == periodValue;

  // The sub-count is the quarter-cycle phase, or two prescaler bits.
  assign subCount = sel1 ? pre[1:0] : (sel4 ? pre[3:2] : pre[5:4]);
  assign periodStart = tick && periodMatch;
  assign lastSlice = run && periodMatch && (subCount == SUB_LAST);

  always_ff @(posedge mclk or negedge resetn) begin
    if (!resetn) begin
      pre <= '0;
      timer <= '0;
    end else if (!run) begin
      pre <= '0;
      timer <= '0;
    end else if (tick) begin
      pre <= '0;
      timer <= periodMatch ? '0 : timer + 1'b1;
    end else begin
      pre <= pre + 1'b1;
    end
  end

endmodule

// ==== tb_epwm_steering.sv ====
// Self-checking bench for the PWM output steering block.
`define CHK(a, e) begin totalChecks++; if ((a) !== (e)) begin badCount++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_epwm_steering
  import epwm_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic resetn = 1'b0;
  logic [ADDR_W-1:0] regAddr = '0;
  logic [DATA_W-1:0] regWrData = '0;
  logic [DATA_W-1:0] regRdData;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic outA, outAEn, outB, outBEn, outC, outCEn, outD, outDEn;
  logic [3:0] pin;
  int badCount = 0;
  int totalChecks = 0;
  int hi, lo, n;

  always #5 mclk = ~mclk;

  epwm_steering u_epwm_steering (.mclk(mclk), .resetn(resetn), .regAddr(regAddr),
    .regWrData(regWrData), .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
    .outA(outA), .outAEn(outAEn), .outB(outB), .outBEn(outBEn),
    .outC(outC), .outCEn(outCEn), .outD(outD), .outDEn(outDEn));
  epwm_switch_model u_epwm_switch_model (.drive({outD, outC, outB, outA}),
    .driveEn({outDEn, outCEn, outBEn, outAEn}), .gate(pin));

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWrData <= d;
    regWrite <= 1'b1;
    @(posedge mclk);
    regWrite <= 1'b0;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    @(posedge mclk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge mclk);
    regRead <= 1'b0;
    @(negedge mclk);
    `CHK(regRdData, e)
  endtask

  // Measures one high phase and the following low phase of a pin.
  task automatic meas(input int i);
    hi = 0;
    lo = 0;
    @(negedge mclk);
    for (n = 0; n < 600 && pin[i] !== 1'b0; n++) @(negedge mclk);
    for (n = 0; n < 600 && pin[i] !== 1'b1; n++) @(negedge mclk);
    while (pin[i] === 1'b1 && hi < 600) begin
      hi++;
      @(negedge mclk);
    end
    while (pin[i] !== 1'b1 && lo < 600) begin
      lo++;
      @(negedge mclk);
    end
  endtask

  task automatic t_regs();
    rdc(REG_CTRL, 32'h0000_f000);
    rdc(REG_PERIOD, 32'h0000_00ff);
    rdc(REG_DEADBAND, 32'h0000_0000);
    rdc(8'h40, 32'h0000_0000);
    wr(REG_STATUS, 32'hffff_ffff);
    rdc(REG_CTRL, 32'h0000_f000);
    wr(REG_PERIOD, 32'h0000_0003);
    wr(REG_DUTY, 32'h0000_0006);
    rdc(REG_DUTY, 32'h0000_0006);
    rdc(REG_LATCH, 32'h0000_0000);
  endtask

  task automatic t_single();
    wr(REG_CTRL, 32'h0000_a501);
    repeat (5) @(negedge mclk);
    `CHK(pin[0], 1'b0)
    meas(0);
    `CHK(hi, 6)
    `CHK(hi + lo, 16)
    meas(2);
    `CHK(hi, 6)
    `CHK(outBEn, 1'b0)
    rdc(REG_LATCH, 32'h0000_0006);
  endtask

  task automatic t_half();
    wr(REG_DEADBAND, 32'h0000_0001);
    wr(REG_CTRL, 32'h0000_c00d);
    repeat (40) @(negedge mclk);
    meas(0);
    `CHK(hi, 2)
    meas(1);
    `CHK(lo, 6)
    `CHK(hi, 10)
    `CHK(outCEn, 1'b0)
    wr(REG_DEADBAND, 32'h0000_0002);
    repeat (40) @(negedge mclk);
    meas(0);
    `CHK(hi, 0)
  endtask

  task automatic t_full();
    wr(REG_CTRL, 32'h0000_0023);
    repeat (150) @(negedge mclk);
    `CHK(pin[2:0], 3'b001)
    meas(3);
    `CHK(hi, 24)
    `CHK(hi + lo, 64)
    // Duty stays well below full, so reversing needs no prior duty cut.
    wr(REG_CTRL, 32'h0000_0027);
    repeat (2) @(negedge mclk);
    `CHK(pin[3], 1'b0)
    for (n = 0; n < 600 && pin[2] !== 1'b1; n++) @(negedge mclk);
    `CHK(pin[0], 1'b0)
    for (n = 0; n < 600 && pin[1] !== 1'b1; n++) @(negedge mclk);
    `CHK(n, 4)
    meas(1);
    `CHK(hi, 24)
    `CHK({pin[3], pin[2], pin[0]}, 3'b010)
    wr(REG_CTRL, 32'h0000_0000);
    repeat (3) @(negedge mclk);
    `CHK(pin, 4'h0)
  endtask

  task automatic endOfTest();
    $display("checks=%0d errors=%0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk);
    badCount++;
    endOfTest();
  end

  initial begin
    repeat (12) @(posedge mclk);
    resetn <= 1'b1;
    t_regs();
    t_single();
    t_half();
    t_full();
    endOfTest();
  end
endmodule
